// file: hdl/angle_tracker.sv
// Digital side of a type II angle tracking loop with programmable resolution.
// Assumes a sampled input angle on the same clock, loss pins from outside.
//
// Behaviour
// RULE1 - The held angle is an up/down counter moved by oscillator pulses.
// RULE2 - The counter is steered to drive input minus counter angle to zero.
// RULE3 - Error is integrated into a rate; the counter integrates the rate.
// RULE4 - Fault flag goes low when error exceeds 65 LSBs of selected resolution.
// RULE5 - Fault flag returns high once the error settles within the threshold.
// RULE6 - Fault flag goes low on over-velocity or when the loop cannot null.
// RULE7 - Fault flag goes low on signal loss, reference loss or both.
// RULE8 - Select codes 00,01,10,11 choose 10,12,14,16 bit resolution.
// RULE9 - Resolution may change while converting, with no restart.
// RULE10 - Select inputs are latched only at the trailing edge of the busy pulse.
// RULE11 - Angle bits below the selected resolution's LSB are driven zero.
// RULE12 - The host starts in 14 or 16 bit and only later goes lower.
// RULE13 - In the low settings the system avoids large steps and accelerations.
// RULE14 - The host should prefer 14 bit where its dynamics suffice.
// RULE15 - Each counter update shows a busy pulse of 0.4 to 1.0 us.
// RULE16 - Angle output changes about 50 ns after the busy leading edge.
// RULE17 - The counter wraps modulo full scale in both directions.
// RULE18 - Each pulse steps one selected LSB, direction from integrated error sign.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module angle_tracker
   import tracker_pkg::*;
#(
   parameter int VEL_WIDTH = 24
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [tracker_pkg::ANGLE_WIDTH-1:0] input_angle,
   input wire logic [1:0] res_sel,
   input wire logic signal_loss,
   input wire logic reference_loss,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack,
   output logic [tracker_pkg::ANGLE_WIDTH-1:0] angle_out,
   output logic counter_update_pulse,
   output logic fault_n,
   output logic irq
);
   import tracker_pkg::*;

   localparam int AW = ANGLE_WIDTH;
   localparam int A_BUSY_LAST = BUSY_CYC - 1;
   localparam int A_DATA_DLY = DATA_DELAY_CYC;

   generate
      if (VEL_WIDTH < AW + 2 || VEL_WIDTH > 31) begin : g_bad_width
         $error("VEL_WIDTH must lie between ANGLE_WIDTH+2 and 31");
      end
      if (BUSY_CYC > BUSY_MAX_CYC || DATA_DELAY_CYC >= BUSY_CYC) begin : g_bad_timing
         $error("Busy pulse timing does not fit the clock rate");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   logic [1:0] res_sel_s;
   logic [1:0] loss_s;

   sync2 #(.WIDTH(4)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({res_sel, reference_loss, signal_loss}),
      .q({res_sel_s, loss_s})
   );

   ////////////////////////////////////////////////////////////////////////////
   // State declarations.
   logic [4:0] ctrl_q;
   fault_type irq_stat_q;
   fault_type irq_mask_q;
   fault_type cause;
   logic [1:0] res_q;
   logic [AW-1:0] phi_q;
   logic signed [VEL_WIDTH-1:0] vel_q;
   logic [VEL_WIDTH-1:0] acc_q;
   logic pend_q;
   logic pend_up_q;
   logic ovf_q;
   logic sat_q;
   pulse_state_type state_q;
   logic [7:0] busy_cnt_q;
   logic ack_q;
   logic [31:0] rdat_q;

   ////////////////////////////////////////////////////////////////////////////
   // Resolution decode.
   logic [AW-1:0] step;
   logic [AW-1:0] res_mask;
   logic [AW-1:0] err_thresh;

   // RULE8 select decode.
   always_comb begin
      unique case (res_q)
         RES_10: step = 16'h0040;
         RES_12: step = 16'h0010;
         RES_14: step = 16'h0004;
         RES_16: step = 16'h0001;
      endcase
      res_mask = ~(step - 16'h0001);
      err_thresh = AW'(ERR_THRESH_LSB * step);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tracking error and integrator.
   logic [AW-1:0] diff;
   logic [AW-1:0] err_abs;
   logic signed [VEL_WIDTH-1:0] err_ext;
   logic signed [VEL_WIDTH:0] vel_sum;
   logic signed [VEL_WIDTH:0] vel_max;
   logic loop_run;
   logic [3:0] gain_shift;

   assign loop_run = ctrl_q[CTRL_RUN_BIT];
   assign gain_shift = ctrl_q[CTRL_GAIN_LSB +: 4];
   // RULE2 wrapped difference of input and counter angle.
   assign diff = input_angle - phi_q;
   assign err_abs = diff[AW-1] ? (~diff + 16'h0001) : diff;
   assign err_ext = VEL_WIDTH'($signed(diff)) >>> gain_shift;
   assign vel_sum = (VEL_WIDTH+1)'(vel_q) + (VEL_WIDTH+1)'(err_ext);
   assign vel_max = (VEL_WIDTH+1)'({1'b0, {(VEL_WIDTH-1){1'b1}}});

   // RULE3 first integration with saturation.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         vel_q <= '0;
         sat_q <= 1'b0;
      end else if (loop_run) begin
         if (vel_sum > vel_max) begin
            vel_q <= VEL_WIDTH'(vel_max);
            sat_q <= 1'b1;
         end else if (vel_sum < -vel_max) begin
            vel_q <= VEL_WIDTH'(-vel_max);
            sat_q <= 1'b1;
         end else begin
            vel_q <= VEL_WIDTH'(vel_sum);
            sat_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator: a phase accumulator whose carry requests one count.
   logic [VEL_WIDTH-1:0] vel_abs;
   logic [VEL_WIDTH:0] acc_sum;
   logic carry;
   logic take;

   assign vel_abs = vel_q[VEL_WIDTH-1] ? VEL_WIDTH'(-vel_q) : VEL_WIDTH'(vel_q);
   assign acc_sum = {1'b0, acc_q} + {1'b0, vel_abs};
   assign carry = loop_run && acc_sum[VEL_WIDTH];
   assign take = (state_q == ST_IDLE) && pend_q;

   // RULE3 oscillator rate follows the integrated error.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_q <= '0;
      end else if (loop_run) begin
         acc_q <= acc_sum[VEL_WIDTH-1:0];
      end
   end

   // RULE6 a pulse that cannot be served marks over-velocity.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pend_q <= 1'b0;
         pend_up_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         if (carry) begin
            pend_q <= 1'b1;
            pend_up_q <= !vel_q[VEL_WIDTH-1];
         end else if (take) begin
            pend_q <= 1'b0;
         end
         if (carry && pend_q && !take) begin
            ovf_q <= 1'b1;
         end else if (take) begin
            ovf_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Busy pulse sequencer, counter and resolution latch.
   logic busy_end;

   assign busy_end = (state_q == ST_BUSY) && (busy_cnt_q == 8'(BUSY_CYC - 1));

   // RULE15 fixed-width busy pulse per update.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         busy_cnt_q <= 8'h00;
         counter_update_pulse <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               busy_cnt_q <= 8'h00;
               if (take) begin
                  state_q <= ST_BUSY;
                  counter_update_pulse <= 1'b1;
               end
            end
            ST_BUSY: begin
               busy_cnt_q <= busy_cnt_q + 8'h01;
               if (busy_end) begin
                  state_q <= ST_IDLE;
                  counter_update_pulse <= 1'b0;
               end
            end
         endcase
      end
   end

   // RULE1 RULE18 one selected LSB per pulse; RULE17 wraps by width.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phi_q <= '0;
      end else if (take) begin
         phi_q <= pend_up_q ? phi_q + step : phi_q - step;
      end
   end

   // RULE10 RULE9 select latched at the busy trailing edge, no restart.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         res_q <= RES_RESET;
      end else if (busy_end) begin
         res_q <= res_sel_s;
      end
   end

   // RULE16 RULE11 delayed, zero-filled angle output.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         angle_out <= '0;
      end else if (state_q == ST_BUSY && busy_cnt_q == 8'(DATA_DELAY_CYC - 1)) begin
         angle_out <= phi_q & res_mask;
      end else if (busy_end) begin
         // Re-masked with the resolution that is latched at this same edge.
         angle_out <= angle_out & ~(res_sel_s == RES_10 ? 16'h003F : res_sel_s == RES_12 ?
            16'h000F : res_sel_s == RES_14 ? 16'h0003 : 16'h0000);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault flag.
   // RULE4 RULE6 RULE7 fault causes.
   always_comb begin
      cause.track_err = err_abs > err_thresh;
      cause.overvel = ovf_q;
      cause.null_fail = sat_q;
      cause.sig_loss = loss_s[0];
      cause.ref_loss = loss_s[1];
   end

   // RULE4 RULE5 flag low while any cause stands.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fault_n <= 1'b1;
      end else begin
         fault_n <= !(|cause);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave, answering one cycle after the strobe.
   logic wr_en;

   assign wr_en = wb_cyc && wb_stb && wb_we && ack_q && wb_sel[0];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q <= wb_cyc && wb_stb && !ack_q;
         unique case (wb_adr)
            CTRL_OFFSET: rdat_q <= {27'h0, ctrl_q};
            STATUS_OFFSET: rdat_q <= {24'h0, cause, res_q, fault_n};
            ANGLE_OFFSET: rdat_q <= {16'h0, angle_out};
            VEL_OFFSET: rdat_q <= 32'(vel_q);
            IRQ_STAT_OFFSET: rdat_q <= {27'h0, irq_stat_q};
            IRQ_MASK_OFFSET: rdat_q <= {27'h0, irq_mask_q};
            default: rdat_q <= 32'h00000000;
         endcase
      end
   end

   assign wb_ack = ack_q;
   assign wb_dat_o = rdat_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= CTRL_RESET;
         irq_mask_q <= IRQ_MASK_RESET;
      end else if (wr_en) begin
         if (wb_adr == CTRL_OFFSET) begin
            ctrl_q <= wb_dat_i[4:0];
         end
         if (wb_adr == IRQ_MASK_OFFSET) begin
            irq_mask_q <= wb_dat_i[4:0];
         end
      end
   end

   // Sticky causes; a cause present in the clearing cycle keeps its bit.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_q <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_en && wb_adr == IRQ_STAT_OFFSET) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_i[4:0]) | cause;
         end else begin
            irq_stat_q <= irq_stat_q | cause;
         end
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_busy_width: assert property (@(posedge clk) disable iff (!rstn) // RULE15
      $rose(counter_update_pulse) |-> ##A_BUSY_LAST counter_update_pulse ##1
      !counter_update_pulse)
      else $error("Busy pulse width wrong");

   a_data_delay: assert property (@(posedge clk) disable iff (!rstn) // RULE16
      $rose(counter_update_pulse) |-> $stable(angle_out) ##A_DATA_DLY
      (angle_out == (phi_q & res_mask)))
      else $error("Angle output not updated after the data delay");

   a_zero_fill: assert property (@(posedge clk) disable iff (!rstn) // RULE11
      (angle_out & ~res_mask) == 16'h0000)
      else $error("Unused low angle bits not zero");

   a_count_step: assert property (@(posedge clk) disable iff (!rstn) // RULE18
      $rose(counter_update_pulse) |-> ((phi_q - $past(phi_q)) == $past(step)) ||
      ((phi_q - $past(phi_q)) == AW'(16'h0000 - $past(step))))
      else $error("Counter step is not one selected LSB");

   a_count_hold: assert property (@(posedge clk) disable iff (!rstn) // RULE1
      !$rose(counter_update_pulse) |-> $stable(phi_q))
      else $error("Counter moved without an update pulse");

   a_res_latch: assert property (@(posedge clk) disable iff (!rstn) // RULE10
      $changed(res_q) |-> $fell(counter_update_pulse) && res_q == $past(res_sel_s))
      else $error("Resolution latched outside the busy trailing edge");

   a_track_fault: assert property (@(posedge clk) disable iff (!rstn) // RULE4
      cause.track_err |=> !fault_n)
      else $error("Large tracking error not flagged");

   a_fault_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE5
      !(|cause) |=> fault_n)
      else $error("Fault flag not released after settling");

   a_ovf_fault: assert property (@(posedge clk) disable iff (!rstn) // RULE6
      (ovf_q || sat_q) |=> !fault_n)
      else $error("Over-velocity or null failure not flagged");

   a_loss_fault: assert property (@(posedge clk) disable iff (!rstn) // RULE7
      (loss_s != 2'b00) |=> !fault_n)
      else $error("Input loss not flagged");

   a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (irq == $past(|(irq_stat_q & irq_mask_q))))
      else $error("Interrupt does not follow masked status");

endmodule

// file: shared/tracker_pkg.sv
// Constants, register map and shared types of the angle tracking counter.
// Assumes a single 50 MHz clock domain and a classic Wishbone register bus.
package tracker_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing.
   localparam int CLK_PERIOD_NS = 20;
   localparam int BUSY_MIN_NS = 400;
   localparam int BUSY_MAX_NS = 1000;
   localparam int DATA_DELAY_NS = 50;
   localparam int BUSY_CYC = (BUSY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;
   localparam int DATA_DELAY_CYC = (DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Angle and loop.
   localparam int ANGLE_WIDTH = 16;
   localparam int ERR_THRESH_LSB = 65;
   localparam logic [1:0] RES_10 = 2'h0;
   localparam logic [1:0] RES_12 = 2'h1;
   localparam logic [1:0] RES_14 = 2'h2;
   localparam logic [1:0] RES_16 = 2'h3;
   localparam logic [1:0] RES_RESET = RES_16;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] ANGLE_OFFSET = 8'h08;
   localparam logic [7:0] VEL_OFFSET = 8'h0C;
   localparam logic [7:0] IRQ_STAT_OFFSET = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h14;

   // Control fields: loop gain shift and loop run enable.
   localparam int CTRL_GAIN_LSB = 0;
   localparam int CTRL_RUN_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h14;
   // Status fields.
   localparam int STAT_FAULT_BIT = 0;
   localparam int STAT_RES_LSB = 1;
   localparam int STAT_CAUSE_LSB = 3;
   localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Fault causes, used for live status, sticky status and mask alike.
   typedef struct packed {
      logic ref_loss;
      logic sig_loss;
      logic null_fail;
      logic overvel;
      logic track_err;
   } fault_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } pulse_state_type;

endpackage

// file: hdl/sync2.sv
// Two-flop synchroniser for slow asynchronous levels.
// Assumes the inputs change slowly compared with the clock.
`timescale 1ns/100ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

// file: tb/tx_model.sv
// Model of the transmitter and host pins that face the angle tracker.
// Assumes the bench calls its tasks from one process, on the tracker clock.
`timescale 1ns/100ps
module tx_model
   import tracker_pkg::*;
(
   input wire logic clk,
   input wire logic [tracker_pkg::ANGLE_WIDTH-1:0] angle_fb,
   output logic [tracker_pkg::ANGLE_WIDTH-1:0] input_angle,
   output logic [1:0] res_sel,
   output logic signal_loss,
   output logic reference_loss
);
   logic follow_q;
   logic [ANGLE_WIDTH-1:0] offset_q;

   ////////////////////////////////////////////////////////////////////////////
   // start at high resolution.
   initial begin
      follow_q = 1'b0;
      offset_q = '0;
      input_angle = '0;
      res_sel = RES_16;
      signal_loss = 1'b0;
      reference_loss = 1'b0;
   end

   always @(posedge clk) begin
      if (follow_q) begin
         input_angle <= angle_fb + offset_q;
      end
   end

   task automatic set_angle(input logic [ANGLE_WIDTH-1:0] a);
      @(posedge clk);
      follow_q <= 1'b0;
      input_angle <= a;
   endtask

   task automatic set_follow(input logic [ANGLE_WIDTH-1:0] off);
      @(posedge clk);
      offset_q <= off;
      follow_q <= 1'b1;
   endtask

   task automatic set_res(input logic [1:0] c);
      @(posedge clk);
      res_sel <= c;
   endtask

   task automatic set_loss(input logic s, input logic r);
      @(posedge clk);
      signal_loss <= s;
      reference_loss <= r;
   endtask
endmodule

// file: tb/tb_angle_tracker.sv
// Self-checking bench of the angle tracker with a pin model on its far side.
// Assumes the design answers each Wishbone request and runs on a 50 MHz clock.
`timescale 1ns/100ps
module tb_angle_tracker;
   import tracker_pkg::*;
   logic clk;
   logic rstn;
   logic wb_cyc;
   logic wb_stb;
   logic wb_we;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack;
   logic [15:0] input_angle;
   logic [15:0] angle_out;
   logic [1:0] res_sel;
   logic signal_loss;
   logic reference_loss;
   logic busy;
   logic fault_n;
   logic irq;
   logic [31:0] rd;
   int miscompares = 0;
   int total_checks = 0;

   angle_tracker dut (.clk(clk), .rstn(rstn), .input_angle(input_angle), .res_sel(res_sel),
      .signal_loss(signal_loss), .reference_loss(reference_loss), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .angle_out(angle_out),
      .counter_update_pulse(busy), .fault_n(fault_n), .irq(irq));

   tx_model tx (.clk(clk), .angle_fb(angle_out), .input_angle(input_angle),
      .res_sel(res_sel), .signal_loss(signal_loss), .reference_loss(reference_loss));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (miscompares == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic tmo();
      miscompares++;
      $display("unexpected at %0t: wait ran out", $time);
      stop_test();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // The answer is taken at the rising edge that shows ack; release follows that edge.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= 4'hF;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) tmo();
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask

   task automatic wait_busy(input logic v);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (busy !== v && n < 5000);
      if (busy !== v) tmo();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_thresh();
      logic [15:0] ang [4] = '{16'h0041, 16'h0042, 16'hFFBF, 16'hFFBE};
      logic exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      wb(1'b1, CTRL_OFFSET, 32'h04);
      for (int i = 0; i < 4; i++) begin
         tx.set_angle(ang[i]);
         repeat (5) @(negedge clk);
         chk(fault_n, exp[i]);
      end
   endtask

   task automatic t_update();
      int w;
      int at;
      logic [15:0] a0;
      tx.set_angle(16'hFFE0);
      wb(1'b1, CTRL_OFFSET, 32'h14);
      wait_busy(1'b1);
      a0 = angle_out;
      w = 0;
      at = 0;
      while (busy === 1'b1 && w < 60) begin
         @(negedge clk);
         w++;
         if (at == 0 && angle_out !== a0) at = w;
      end
      chk(w, BUSY_CYC);
      chk(at, DATA_DELAY_CYC);
      chk(a0, 16'h0000);
      chk(angle_out, 16'hFFFF);
   endtask

   task automatic t_irq();
      wb(1'b1, IRQ_MASK_OFFSET, 32'h08);
      tx.set_loss(1'b1, 1'b0);
      repeat (6) @(negedge clk);
      chk(fault_n, 1'b0);
      chk(irq, 1'b1);
      wb(1'b0, IRQ_STAT_OFFSET, 32'h0);
      chk(rd & 32'h08, 32'h08);
      tx.set_loss(1'b0, 1'b0);
      repeat (6) @(negedge clk);
      wb(1'b1, IRQ_STAT_OFFSET, 32'h08);
      wb(1'b0, IRQ_STAT_OFFSET, 32'h0);
      chk(rd & 32'h08, 32'h0);
      repeat (2) @(negedge clk);
      chk(irq, 1'b0);
      wb(1'b1, IRQ_MASK_OFFSET, 32'h0);
      tx.set_loss(1'b0, 1'b1);
      repeat (6) @(negedge clk);
      chk(fault_n, 1'b0);
      chk(irq, 1'b0);
      wb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd[7], 1'b1);
      tx.set_loss(1'b0, 1'b0);
      wb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
   endtask

   task automatic t_res();
      logic [1:0] rc [4] = '{RES_14, RES_10, RES_12, RES_16};
      logic [15:0] zm [4] = '{16'h0003, 16'h003F, 16'h000F, 16'h0000};
      logic [1:0] prev;
      prev = RES_16;
      wb(1'b1, CTRL_OFFSET, 32'h10);
      tx.set_follow(16'h0100);
      for (int i = 0; i < 4; i++) begin
         wait_busy(1'b1);
         tx.set_res(rc[i]);
         wb(1'b0, STATUS_OFFSET, 32'h0);
         chk(rd[2:1], prev);
         wait_busy(1'b0);
         repeat (2) @(negedge clk);
         wb(1'b0, STATUS_OFFSET, 32'h0);
         chk(rd[2:1], rc[i]);
         chk(angle_out & zm[i], 16'h0000);
         prev = rc[i];
      end
   endtask

   task automatic t_null();
      wb(1'b1, CTRL_OFFSET, 32'h10);
      tx.set_follow(16'h7FFF);
      repeat (600) @(negedge clk);
      wb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd[5], 1'b1);
      chk(fault_n, 1'b0);
      wb(1'b0, VEL_OFFSET, 32'h0);
      chk(rd, 32'h007FFFFF);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'hF;
      wb_dat_i = 32'h0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      chk({angle_out, busy, fault_n, irq, wb_ack}, {16'h0000, 4'b0100});
      @(posedge clk);
      rstn <= 1'b1;
      wb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd, 32'h14);
      wb(1'b0, IRQ_MASK_OFFSET, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd[2:1], RES_16);
      t_thresh();
      t_update();
      t_irq();
      t_res();
      t_null();
      stop_test();
   end
endmodule
